// File: design/smw_event_logic.sv
/*
 * Wake and system management event aggregation with LED drive.
 * Status, enable and routing registers sit in one runtime I/O window;
 * the group SMI and wake outputs are driven with programmable level and
 * driver type, and two LED pins are switched or blinked.
 * Assumes all inputs are synchronous to CLK and that keyboard, mouse,
 * infrared frame detection and function interrupts come from elsewhere.
 */
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Six pins with dual edge selected raise events on both edges.
// - Dual-edge pin ignores direction, polarity, driver, except data bit.
// - Dual-edge pin requests only when enabled and dual edge selected.
// - Either edge sets wake and SMI status; write 1 clears.
// - Misc status gathers all six pins, both edges, in either edge mode, write 1 clears.
// - Status bits record regardless of dual-edge selection, and of enables save global wake and wake three bit 3.
// - Two LEDs independently on, off or blinking via registers 0x5D, 0x5E.
// - Blinking is timed by the 32 kHz clock; no clock, no blink.
// - SMI pin polarity and driver from control; default low, open drain.
// - Internal group SMI is OR of enabled true status across SMI enables.
// - SMI enable two bit 7 gates pin, bit 6 gates IRQ2 stream.
// - SMI enable two bit 5 routes group SMI into wake logic.
// - GPIO and fan SMI status set on polarity edge; write 1 clears.
// - GPIO and fan SMI contribution is latched status AND enable.
// - Function SMI bits clear at source; infrared clears on read.
// - Global wake enable clear blocks wake; set passes enabled sources.
// - Global wake status sets on enabled source, global enable or not.
// - Global wake status holds while any enabled event status remains set.
// - GPIO wake status on polarity edge, both for dual; write 1 clears.
// - Wake sources: ring, infrared frame, keyboard, mouse, GPIO, fan tach.
// - Wake pin polarity and driver from control; default low, open drain.
// - Wake status three bit 3 shows routed group SMI; write 1 clears.
// - Wake enable three bit 3 with that status drives wake pin.
// - Pin control bit 0 direction, bit 1 polarity, bit 7 driver type.
module smw_event_logic
	import smw_pkg::*;
(
	input wire logic CLK,
	input wire logic NRST,
	input wire smw_io_req_type IO_REQ,
	output logic [7:0] IO_RDATA,
	input wire logic [GPIO_COUNT-1:0] GPIO_IN,
	input wire logic [1:0] FAN_TACH,
	input wire logic RING_INDICATOR_A_N,
	input wire logic RING_INDICATOR_B_N,
	input wire logic IR_FRAME_VALID,
	input wire logic KBD_WAKE_EDGE,
	input wire logic MOUSE_WAKE_EDGE,
	input wire logic [3:0] FUNC_IRQ,
	input wire logic [1:0] KM_IRQ,
	input wire logic INFRARED_EVENT,
	input wire logic CLK32K,
	output logic GROUP_SMI_INTERNAL,
	output logic SERIRQ_SMI,
	output smw_pin_type GROUP_SMI_PIN,
	output smw_pin_type WAKE_EVENT_PIN,
	output smw_pin_type LED_PIN_A,
	output smw_pin_type LED_PIN_B
);

	function automatic logic hit(input smw_io_req_type r,
			input logic [7:0] a);
		hit = r.wr && (r.addr == a);
	endfunction : hit

	// Write-one-to-clear; a set in the same cycle wins
	function automatic logic [7:0] w1c(input logic [7:0] cur,
			input logic [7:0] set, input logic clr,
			input logic [7:0] data, input logic [7:0] mask);
		w1c = (set | (cur & ~(clr ? data : 8'h00))) & mask;
	endfunction : w1c

	function automatic smw_pin_type drive_pin(input logic active,
			input logic [7:0] ctrl);
		logic level;
		level = ctrl[CTRL_POL] ? active : ~active;
		if (ctrl[CTRL_TYPE]) begin
			drive_pin = '{o: level, oe_n: 1'b0};
		end else begin
			drive_pin = '{o: 1'b0, oe_n: level};
		end
	endfunction : drive_pin

	logic [7:0] wake_gsts, wake_gen;
	logic [7:0] wake_sts1, wake_sts2, wake_sts3;
	logic [7:0] wake_en1, wake_en2, wake_en3;
	logic [7:0] smi_sts3, smi_sts4;
	logic [7:0] smi_en1, smi_enable_two, smi_en3, smi_en4;
	logic [7:0] misc_edge_status;
	logic [7:0] smi_pin_control, wake_pin_control;
	logic [7:0] dual_edge_event, fan_pol;
	logic [7:0] gpio_ctrl [GPIO_COUNT];
	logic [7:0] led_control_first, led_control_second;
	logic infrared_latch;
	logic [GPIO_COUNT-1:0] gpio_prev;
	logic [1:0] fan_prev;
	logic ring_a_prev, ring_b_prev;
	logic clk32_prev;
	logic [13:0] blink_count;
	logic blink_phase;

	logic [GPIO_COUNT-1:0] gpio_pol, gpio_dir, gpio_any, gpio_set;
	logic [1:0] fan_set;
	logic [7:0] wake1_set, wake3_set;
	logic [7:0] smi_sts1, smi_status_two;
	logic group_smi, wake_pending, wake_active, devint_cond;
	logic smi2_read;
	logic [7:0] next_rdata;

	always_comb begin
		for (int i = 0; i < GPIO_COUNT; i++) begin
			gpio_pol[i] = gpio_ctrl[i][CTRL_POL];
			gpio_dir[i] = gpio_ctrl[i][CTRL_DIR];
		end
	end

	// Dual edge ignores direction and polarity; otherwise an output pin is
	// excluded and only the polarity-selected edge counts
	assign gpio_any = GPIO_IN ^ gpio_prev;
	assign gpio_set = (dual_edge_event[GPIO_COUNT-1:0] & gpio_any) |
		(~dual_edge_event[GPIO_COUNT-1:0] & gpio_dir &
		(GPIO_IN ^ gpio_pol) & ~(gpio_prev ^ gpio_pol));
	assign fan_set = (FAN_TACH ^ fan_pol[1:0]) &
		~(fan_prev ^ fan_pol[1:0]);
	assign wake1_set = {3'h0, MOUSE_WAKE_EDGE, KBD_WAKE_EDGE,
		IR_FRAME_VALID, ~RING_INDICATOR_B_N & ring_b_prev,
		~RING_INDICATOR_A_N & ring_a_prev};
	assign devint_cond = group_smi && smi_enable_two[SMI_ENABLE_TWO_WAKE];
	assign wake3_set = {4'h0, devint_cond, 1'b0, fan_set};
	assign smi_sts1 = {4'h0, FUNC_IRQ};
	assign smi_status_two = {5'h0, infrared_latch, KM_IRQ};
	assign smi2_read = IO_REQ.rd && (IO_REQ.addr == ADDR_SMI_STATUS_TWO);

	assign group_smi = |(smi_sts1 & smi_en1) |
		|(smi_status_two & smi_enable_two & 8'h07) |
		|(smi_sts3 & smi_en3) | |(smi_sts4 & smi_en4);
	// Dual-edge pins only reach the request path through these gates
	assign wake_pending = |(wake_sts1 & wake_en1) |
		|(wake_sts2 & wake_en2) | |(wake_sts3 & wake_en3);
	assign wake_active = wake_gen[0] && wake_pending;

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			gpio_prev <= '0;
			fan_prev <= 2'h0;
			ring_a_prev <= 1'b1;
			ring_b_prev <= 1'b1;
			clk32_prev <= 1'b0;
		end else begin
			gpio_prev <= GPIO_IN;
			fan_prev <= FAN_TACH;
			ring_a_prev <= RING_INDICATOR_A_N;
			ring_b_prev <= RING_INDICATOR_B_N;
			clk32_prev <= CLK32K;
		end
	end

	// Event status: set regardless of enables, save wake status three bit 3
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			wake_sts1 <= REG_RESET;
			wake_sts2 <= REG_RESET;
			wake_sts3 <= REG_RESET;
			smi_sts3 <= REG_RESET;
			smi_sts4 <= REG_RESET;
			misc_edge_status <= REG_RESET;
		end else begin
			wake_sts1 <= w1c(wake_sts1, wake1_set,
				hit(IO_REQ, ADDR_WAKE_STS1), IO_REQ.wdata, MASK_WAKE1);
			wake_sts2 <= w1c(wake_sts2, 8'(gpio_set),
				hit(IO_REQ, ADDR_WAKE_STS2), IO_REQ.wdata,
				MASK_GPIO);
			wake_sts3 <= w1c(wake_sts3, wake3_set,
				hit(IO_REQ, ADDR_WAKE_STS3), IO_REQ.wdata,
				MASK_WAKE3);
			smi_sts3 <= w1c(smi_sts3, 8'(gpio_set),
				hit(IO_REQ, ADDR_SMI_STS3), IO_REQ.wdata,
				MASK_GPIO);
			smi_sts4 <= w1c(smi_sts4, {6'h0, fan_set},
				hit(IO_REQ, ADDR_SMI_STS4), IO_REQ.wdata, MASK_FAN);
			misc_edge_status <= w1c(misc_edge_status, 8'(gpio_any),
				hit(IO_REQ, ADDR_MISC_STS), IO_REQ.wdata,
				MASK_GPIO);
		end
	end

	// Global status stays up while anything enabled is still pending
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			wake_gsts <= REG_RESET;
		end else begin
			wake_gsts <= w1c(wake_gsts, {7'h0, wake_pending},
				hit(IO_REQ, ADDR_WAKE_GSTS), IO_REQ.wdata,
				MASK_GLOBAL);
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			infrared_latch <= 1'b0;
		end else if (INFRARED_EVENT) begin
			infrared_latch <= 1'b1;
		end else if (smi2_read) begin
			infrared_latch <= 1'b0;
		end
	end

	// Software-owned control registers
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			wake_gen <= REG_RESET;
			wake_en1 <= REG_RESET;
			wake_en2 <= REG_RESET;
			wake_en3 <= REG_RESET;
			smi_en1 <= REG_RESET;
			smi_enable_two <= REG_RESET;
			smi_en3 <= REG_RESET;
			smi_en4 <= REG_RESET;
			smi_pin_control <= PIN_CTRL_RESET;
			wake_pin_control <= PIN_CTRL_RESET;
			dual_edge_event <= REG_RESET;
			fan_pol <= REG_RESET;
			led_control_first <= REG_RESET;
			led_control_second <= REG_RESET;
		end else if (IO_REQ.wr) begin
			if (IO_REQ.addr == ADDR_WAKE_GEN) begin
				wake_gen <= IO_REQ.wdata & MASK_GLOBAL;
			end else if (IO_REQ.addr == ADDR_WAKE_EN1) begin
				wake_en1 <= IO_REQ.wdata & MASK_WAKE1;
			end else if (IO_REQ.addr == ADDR_WAKE_EN2) begin
				wake_en2 <= IO_REQ.wdata & MASK_GPIO;
			end else if (IO_REQ.addr == ADDR_WAKE_EN3) begin
				wake_en3 <= IO_REQ.wdata & MASK_WAKE3;
			end else if (IO_REQ.addr == ADDR_SMI_EN1) begin
				smi_en1 <= IO_REQ.wdata & MASK_SMI1;
			end else if (IO_REQ.addr == ADDR_SMI_ENABLE_TWO) begin
				smi_enable_two <= IO_REQ.wdata & MASK_SMI_ENABLE_TWO;
			end else if (IO_REQ.addr == ADDR_SMI_EN3) begin
				smi_en3 <= IO_REQ.wdata & MASK_GPIO;
			end else if (IO_REQ.addr == ADDR_SMI_EN4) begin
				smi_en4 <= IO_REQ.wdata & MASK_FAN;
			end else if (IO_REQ.addr == ADDR_SMI_PIN_CTRL) begin
				smi_pin_control <= IO_REQ.wdata & MASK_CTRL;
			end else if (IO_REQ.addr == ADDR_WAKE_PIN_CTRL) begin
				wake_pin_control <= IO_REQ.wdata & MASK_CTRL;
			end else if (IO_REQ.addr == ADDR_DUAL_SEL) begin
				dual_edge_event <= IO_REQ.wdata & MASK_GPIO;
			end else if (IO_REQ.addr == ADDR_FAN_POL) begin
				fan_pol <= IO_REQ.wdata & MASK_FAN;
			end else if (IO_REQ.addr == ADDR_LED_FIRST) begin
				led_control_first <= IO_REQ.wdata & MASK_CTRL;
			end else if (IO_REQ.addr == ADDR_LED_SECOND) begin
				led_control_second <= IO_REQ.wdata & MASK_CTRL;
			end
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			for (int i = 0; i < GPIO_COUNT; i++) begin
				gpio_ctrl[i] <= GPIO_CTRL_RESET;
			end
		end else begin
			for (int i = 0; i < GPIO_COUNT; i++) begin
				if (hit(IO_REQ, ADDR_GPIO_CTRL0 + 8'(i))) begin
					gpio_ctrl[i] <= IO_REQ.wdata & MASK_CTRL;
				end
			end
		end
	end

	// Read data is registered; the answer is valid the cycle after rd
	always_comb begin
		next_rdata = 8'h00;
		if (IO_REQ.addr == ADDR_WAKE_GSTS) begin
			next_rdata = wake_gsts;
		end else if (IO_REQ.addr == ADDR_WAKE_GEN) begin
			next_rdata = wake_gen;
		end else if (IO_REQ.addr == ADDR_WAKE_STS1) begin
			next_rdata = wake_sts1;
		end else if (IO_REQ.addr == ADDR_WAKE_STS2) begin
			next_rdata = wake_sts2;
		end else if (IO_REQ.addr == ADDR_WAKE_STS3) begin
			next_rdata = wake_sts3;
		end else if (IO_REQ.addr == ADDR_WAKE_EN1) begin
			next_rdata = wake_en1;
		end else if (IO_REQ.addr == ADDR_WAKE_EN2) begin
			next_rdata = wake_en2;
		end else if (IO_REQ.addr == ADDR_WAKE_EN3) begin
			next_rdata = wake_en3;
		end else if (IO_REQ.addr == ADDR_SMI_STS1) begin
			next_rdata = smi_sts1;
		end else if (IO_REQ.addr == ADDR_SMI_STATUS_TWO) begin
			next_rdata = smi_status_two;
		end else if (IO_REQ.addr == ADDR_SMI_STS3) begin
			next_rdata = smi_sts3;
		end else if (IO_REQ.addr == ADDR_SMI_STS4) begin
			next_rdata = smi_sts4;
		end else if (IO_REQ.addr == ADDR_SMI_EN1) begin
			next_rdata = smi_en1;
		end else if (IO_REQ.addr == ADDR_SMI_ENABLE_TWO) begin
			next_rdata = smi_enable_two;
		end else if (IO_REQ.addr == ADDR_SMI_EN3) begin
			next_rdata = smi_en3;
		end else if (IO_REQ.addr == ADDR_SMI_EN4) begin
			next_rdata = smi_en4;
		end else if (IO_REQ.addr == ADDR_MISC_STS) begin
			next_rdata = misc_edge_status;
		end else if (IO_REQ.addr == ADDR_SMI_PIN_CTRL) begin
			next_rdata = smi_pin_control;
		end else if (IO_REQ.addr == ADDR_WAKE_PIN_CTRL) begin
			next_rdata = wake_pin_control;
		end else if (IO_REQ.addr == ADDR_DUAL_SEL) begin
			next_rdata = dual_edge_event;
		end else if (IO_REQ.addr == ADDR_FAN_POL) begin
			next_rdata = fan_pol;
		end else if (IO_REQ.addr == ADDR_GPIO_DATA) begin
			next_rdata = 8'(GPIO_IN ^ gpio_pol);
		end else if (IO_REQ.addr == ADDR_LED_FIRST) begin
			next_rdata = led_control_first;
		end else if (IO_REQ.addr == ADDR_LED_SECOND) begin
			next_rdata = led_control_second;
		end else begin
			for (int i = 0; i < GPIO_COUNT; i++) begin
				if (IO_REQ.addr == ADDR_GPIO_CTRL0 + 8'(i)) begin
					next_rdata = gpio_ctrl[i];
				end
			end
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			IO_RDATA <= 8'h00;
		end else if (IO_REQ.rd) begin
			IO_RDATA <= next_rdata;
		end
	end

	// Blink timebase counts 32 kHz edges only, so it freezes without them
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			blink_count <= 14'h0000;
			blink_phase <= 1'b0;
		end else if (CLK32K && !clk32_prev) begin
			if (blink_count == LED_HALF_LAST) begin
				blink_count <= 14'h0000;
				blink_phase <= ~blink_phase;
			end else begin
				blink_count <= blink_count + 14'h0001;
			end
		end
	end

	function automatic smw_pin_type led_drive(input logic [7:0] ctrl,
			input logic phase);
		logic lit;
		lit = (ctrl[1:0] == LED_MODE_ON) ||
			(ctrl[1] && phase);
		if (ctrl[CTRL_TYPE]) begin
			led_drive = '{o: lit, oe_n: 1'b0};
		end else begin
			led_drive = '{o: 1'b0, oe_n: ~lit};
		end
	endfunction : led_drive

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			GROUP_SMI_INTERNAL <= 1'b0;
			SERIRQ_SMI <= 1'b0;
			GROUP_SMI_PIN <= PIN_RELEASED;
			WAKE_EVENT_PIN <= PIN_RELEASED;
			LED_PIN_A <= PIN_RELEASED;
			LED_PIN_B <= PIN_RELEASED;
		end else begin
			GROUP_SMI_INTERNAL <= group_smi;
			SERIRQ_SMI <= group_smi && smi_enable_two[SMI_ENABLE_TWO_IRQ2];
			GROUP_SMI_PIN <= drive_pin(group_smi &&
				smi_enable_two[SMI_ENABLE_TWO_PIN], smi_pin_control);
			WAKE_EVENT_PIN <= drive_pin(wake_active,
				wake_pin_control);
			LED_PIN_A <= led_drive(led_control_first, blink_phase);
			LED_PIN_B <= led_drive(led_control_second, blink_phase);
		end
	end

	AST_WAKE_BLOCKED: assert property (@(posedge CLK) disable iff (!NRST)
		!wake_gen[0] && wake_pin_control == PIN_CTRL_RESET |=>
		WAKE_EVENT_PIN == PIN_RELEASED)
		else $error("wake pin active while global enable clear");
	AST_WAKE_DRIVEN: assert property (@(posedge CLK) disable iff (!NRST)
		wake_gen[0] && wake_pending && wake_pin_control == PIN_CTRL_RESET
		|=> WAKE_EVENT_PIN.oe_n == 1'b0)
		else $error("enabled wake event did not pull wake pin low");
	AST_GLOBAL_HOLD: assert property (@(posedge CLK) disable iff (!NRST)
		wake_pending |=> wake_gsts[0])
		else $error("global wake status dropped with events pending");
	AST_MISC_BOTH_EDGES: assert property (@(posedge CLK) disable iff (!NRST)
		$changed(GPIO_IN[0]) |-> ##1 misc_edge_status[0])
		else $error("misc status missed an edge");
	AST_DUAL_SETS_STATUS: assert property (@(posedge CLK)
		disable iff (!NRST)
		dual_edge_event[1] && $fell(GPIO_IN[1]) |=>
		wake_sts2[1] && smi_sts3[1])
		else $error("dual-edge fall did not set wake and SMI status");
	AST_INFRARED_READ_CLEAR: assert property (@(posedge CLK)
		disable iff (!NRST)
		smi2_read && !INFRARED_EVENT |=> !infrared_latch)
		else $error("infrared status survived status read");
	AST_SMI_PIN: assert property (@(posedge CLK) disable iff (!NRST)
		group_smi && smi_enable_two[SMI_ENABLE_TWO_PIN] &&
		smi_pin_control == PIN_CTRL_RESET |=>
		GROUP_SMI_PIN.oe_n == 1'b0 && GROUP_SMI_PIN.o == 1'b0)
		else $error("group SMI pin not driven low");
	AST_IRQ2_GATE: assert property (@(posedge CLK) disable iff (!NRST)
		SERIRQ_SMI |-> $past(smi_enable_two[SMI_ENABLE_TWO_IRQ2]) &&
		GROUP_SMI_INTERNAL)
		else $error("IRQ2 request without enable or SMI");
	AST_DEVINT_ROUTE: assert property (@(posedge CLK) disable iff (!NRST)
		devint_cond |=> wake_sts3[WAKE3_DEVINT])
		else $error("routed group SMI not reflected in wake status");
	AST_LED_OFF: assert property (@(posedge CLK) disable iff (!NRST)
		led_control_first[1:0] == LED_MODE_OFF &&
		!led_control_first[CTRL_TYPE] |=>
		LED_PIN_A == PIN_RELEASED)
		else $error("LED A lit while off");

endmodule : smw_event_logic
`default_nettype wire

// File: include/smw_pkg.sv
/*
 * Constants, register map and carrier types for the wake and system
 * management event block.
 * Assumes an 8-bit runtime I/O window decoded by the host interface
 * logic, so only the offset within the block arrives here.
 */
`default_nettype none
package smw_pkg;
	// Runtime register offsets within the block
	localparam logic [7:0] ADDR_WAKE_GSTS = 8'h00;
	localparam logic [7:0] ADDR_WAKE_GEN = 8'h01;
	localparam logic [7:0] ADDR_WAKE_STS1 = 8'h02;
	localparam logic [7:0] ADDR_WAKE_STS2 = 8'h03;
	localparam logic [7:0] ADDR_WAKE_STS3 = 8'h04;
	localparam logic [7:0] ADDR_WAKE_EN1 = 8'h05;
	localparam logic [7:0] ADDR_WAKE_EN2 = 8'h06;
	localparam logic [7:0] ADDR_WAKE_EN3 = 8'h07;
	localparam logic [7:0] ADDR_SMI_STS1 = 8'h10;
	localparam logic [7:0] ADDR_SMI_STATUS_TWO = 8'h11;
	localparam logic [7:0] ADDR_SMI_STS3 = 8'h12;
	localparam logic [7:0] ADDR_SMI_STS4 = 8'h13;
	localparam logic [7:0] ADDR_SMI_EN1 = 8'h14;
	localparam logic [7:0] ADDR_SMI_ENABLE_TWO = 8'h15;
	localparam logic [7:0] ADDR_SMI_EN3 = 8'h16;
	localparam logic [7:0] ADDR_SMI_EN4 = 8'h17;
	localparam logic [7:0] ADDR_MISC_STS = 8'h18;
	localparam logic [7:0] ADDR_SMI_PIN_CTRL = 8'h20;
	localparam logic [7:0] ADDR_WAKE_PIN_CTRL = 8'h21;
	localparam logic [7:0] ADDR_DUAL_SEL = 8'h22;
	localparam logic [7:0] ADDR_FAN_POL = 8'h23;
	localparam logic [7:0] ADDR_GPIO_DATA = 8'h24;
	localparam logic [7:0] ADDR_GPIO_CTRL0 = 8'h28;
	localparam logic [7:0] ADDR_LED_FIRST = 8'h5d;
	localparam logic [7:0] ADDR_LED_SECOND = 8'h5e;
	localparam int GPIO_COUNT = 6;
	// Writable bits of each register; others read as zero
	localparam logic [7:0] MASK_GLOBAL = 8'h01;
	localparam logic [7:0] MASK_WAKE1 = 8'h1f;
	localparam logic [7:0] MASK_GPIO = 8'h3f;
	localparam logic [7:0] MASK_WAKE3 = 8'h0b;
	localparam logic [7:0] MASK_SMI1 = 8'h0f;
	localparam logic [7:0] MASK_SMI_ENABLE_TWO = 8'he7;
	localparam logic [7:0] MASK_FAN = 8'h03;
	localparam logic [7:0] MASK_CTRL = 8'h83;
	// Field positions
	localparam int CTRL_DIR = 0;
	localparam int CTRL_POL = 1;
	localparam int CTRL_TYPE = 7;
	localparam int SMI_ENABLE_TWO_PIN = 7;
	localparam int SMI_ENABLE_TWO_IRQ2 = 6;
	localparam int SMI_ENABLE_TWO_WAKE = 5;
	localparam int WAKE3_DEVINT = 3;
	localparam int SMI2_INFRARED = 2;
	localparam logic [1:0] LED_MODE_OFF = 2'h0;
	localparam logic [1:0] LED_MODE_ON = 2'h1;
	// Reset values
	localparam logic [7:0] PIN_CTRL_RESET = 8'h00;
	localparam logic [7:0] GPIO_CTRL_RESET = 8'h01;
	localparam logic [7:0] REG_RESET = 8'h00;
	// Blink half period in 32 kHz clock edges (0.5 s)
	localparam int LED_HALF_EDGES = 16384;
	localparam logic [13:0] LED_HALF_LAST = 14'(LED_HALF_EDGES - 1);

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} smw_io_req_type;

	typedef struct packed {
		logic o;
		logic oe_n;
	} smw_pin_type;

	localparam smw_pin_type PIN_RELEASED = '{o: 1'b0, oe_n: 1'b1};
endpackage : smw_pkg
`default_nettype wire

// File: verification/smw_host_model.sv
/*
 * Host power management side: resolves the group SMI and wake wires.
 * Assumes both wires carry pull-ups, as open-drain event lines do.
 */
`timescale 1ns/1ps
`default_nettype none
module smw_host_model
	import smw_pkg::*;
(
	input wire smw_pin_type smi_pin,
	input wire smw_pin_type wake_pin,
	output logic smi_wire,
	output logic wake_wire
);
	// A released wire goes to the pull-up, never to the last driven value
	assign smi_wire = smi_pin.oe_n ? 1'b1 : smi_pin.o;
	assign wake_wire = wake_pin.oe_n ? 1'b1 : wake_pin.o;
	// Window base decode lives on this side, so offsets arrive bare
endmodule : smw_host_model
`default_nettype wire

// File: verification/testbench.sv
/*
 * Self-checking bench for the event block with a host wire model.
 * Assumes the register offsets and reset values of the package.
 */
`timescale 1ns/1ps
`default_nettype none
module testbench import smw_pkg::*;;
	logic CLK, NRST, ck32, ir, kbd, ms, infr, ra, rb;
	logic smi_int, serirq, smi_wire, wake_wire;
	smw_io_req_type req;
	logic [7:0] rdata;
	logic [5:0] gpio;
	logic [8:0] prev;
	logic [1:0] fan, km;
	logic [3:0] func;
	logic [31:0] v;
	smw_pin_type smi_pin, wake_pin, led_a, led_b;
	int fails, n_tests, misc, fanr, rng;
	int cyc = 0;

	smw_event_logic dut_u (.CLK(CLK), .NRST(NRST), .IO_REQ(req),
		.IO_RDATA(rdata), .GPIO_IN(gpio), .FAN_TACH(fan),
		.RING_INDICATOR_A_N(ra), .RING_INDICATOR_B_N(rb),
		.IR_FRAME_VALID(ir), .KBD_WAKE_EDGE(kbd), .MOUSE_WAKE_EDGE(ms),
		.FUNC_IRQ(func), .KM_IRQ(km), .INFRARED_EVENT(infr), .CLK32K(ck32),
		.GROUP_SMI_INTERNAL(smi_int), .SERIRQ_SMI(serirq),
		.GROUP_SMI_PIN(smi_pin), .WAKE_EVENT_PIN(wake_pin),
		.LED_PIN_A(led_a), .LED_PIN_B(led_b));
	smw_host_model host_u (.smi_pin(smi_pin), .wake_pin(wake_pin),
		.smi_wire(smi_wire), .wake_wire(wake_wire));

	initial begin
		CLK = 1'b0;
		forever #50 CLK = ~CLK;
	end
	// Off the CLK grid so the slow clock never lands on a sampling edge
	initial begin
		ck32 = 1'b0;
		forever #15240 ck32 = ~ck32;
	end

	task automatic summarize();
		if (fails == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : summarize

	always @(posedge CLK) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fails = fails + 1;
			summarize();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests = n_tests + 1;
		if (got !== exp) begin
			fails = fails + 1;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge CLK) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge CLK) req <= '0;
	endtask : wr
	task automatic rc(input logic [7:0] a, input logic [7:0] exp);
		@(posedge CLK) req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge CLK) req <= '0;
		#1 chk(rdata, exp);
	endtask : rc
	task automatic idle(input int n);
		repeat (n) @(posedge CLK);
		// Step off the edge so outputs launched there have settled
		#1;
	endtask : idle

	initial begin
		NRST = 1'b0;
		req = '0;
		gpio = '0;
		fan = '0;
		func = '0;
		km = '0;
		{ra, rb} = 2'b11;
		{ir, kbd, ms, infr} = 4'h0;
		fails = 0;
		n_tests = 0;
		v = $urandom(9);
		idle(12);
		NRST <= 1'b1;
		rc(ADDR_LED_FIRST, REG_RESET);
		rc(ADDR_GPIO_CTRL0, GPIO_CTRL_RESET);
		rc(8'h40, 8'h00);
		wr(ADDR_WAKE_EN2, 8'h01);
		wr(ADDR_DUAL_SEL, 8'h01);
		@(posedge CLK) gpio <= 6'h01;
		idle(3);
		rc(ADDR_WAKE_STS2, 8'h01);
		rc(ADDR_MISC_STS, 8'h01);
		rc(ADDR_SMI_STS3, 8'h01);
		rc(ADDR_WAKE_GSTS, 8'h01);
		chk({7'h0, wake_wire}, 8'h01);
		wr(ADDR_WAKE_GEN, 8'h01);
		idle(3);
		chk({7'h0, wake_wire}, 8'h00);
		wr(ADDR_WAKE_GSTS, 8'h01);
		rc(ADDR_WAKE_GSTS, 8'h01);
		wr(ADDR_WAKE_STS2, 8'h01);
		wr(ADDR_WAKE_GSTS, 8'h01);
		rc(ADDR_WAKE_GSTS, 8'h00);
		@(posedge CLK) gpio <= 6'h00;
		idle(3);
		rc(ADDR_WAKE_STS2, 8'h01);
		wr(ADDR_SMI_EN3, 8'h01);
		wr(ADDR_SMI_ENABLE_TWO, 8'h80);
		idle(3);
		chk({7'h0, smi_int}, 8'h01);
		chk({6'h0, serirq, smi_wire}, 8'h00);
		wr(ADDR_SMI_ENABLE_TWO, 8'he0);
		idle(3);
		chk({7'h0, serirq}, 8'h01);
		rc(ADDR_WAKE_STS3, 8'h08);
		wr(ADDR_SMI_STS3, 8'h01);
		wr(ADDR_WAKE_STS2, 8'h01);
		idle(3);
		chk({6'h0, smi_int, smi_wire}, 8'h01);
		chk({7'h0, wake_wire}, 8'h01);
		wr(ADDR_WAKE_EN3, 8'h08);
		idle(3);
		chk({7'h0, wake_wire}, 8'h00);
		wr(ADDR_WAKE_STS3, 8'h08);
		rc(ADDR_WAKE_STS3, 8'h00);
		wr(ADDR_LED_FIRST, 8'h81);
		wr(ADDR_LED_SECOND, 8'h00);
		idle(2);
		chk({4'h0, led_a, led_b}, 8'h09);
		// Blink starts in its dark half; a full half period is far off
		wr(ADDR_LED_SECOND, 8'h82);
		idle(2);
		chk({6'h0, led_b}, 8'h00);
		// Random toggles on every dual pin; the model ORs in each change
		wr(ADDR_DUAL_SEL, 8'h3f);
		wr(ADDR_MISC_STS, 8'h3f);
		misc = 0;
		fanr = 0;
		rng = 0;
		prev = {ra, fan, gpio};
		repeat (20) begin
			@(posedge CLK);
			v = $urandom;
			gpio <= v[5:0];
			fan <= v[7:6];
			ra <= v[8];
			func <= v[12:9];
			km <= v[14:13];
			misc = misc | int'(v[5:0] ^ prev[5:0]);
			fanr = fanr | int'(v[7:6] & ~prev[7:6]);
			rng = rng | int'(prev[8] & ~v[8]);
			prev = v[8:0];
		end
		idle(3);
		rc(ADDR_MISC_STS, 8'(misc));
		rc(ADDR_SMI_STS1, {4'h0, func});
		rc(ADDR_SMI_STS4, 8'(fanr));
		@(posedge CLK) {infr, kbd} <= 2'b11;
		@(posedge CLK) {infr, kbd} <= 2'b00;
		rc(ADDR_SMI_STATUS_TWO, {5'h0, 1'b1, km});
		rc(ADDR_SMI_STATUS_TWO, {5'h0, 1'b0, km});
		rc(ADDR_WAKE_STS1, 8'(rng) | 8'h08);
		wr(ADDR_GPIO_CTRL0, 8'h03);
		rc(ADDR_GPIO_DATA, {2'b00, gpio ^ 6'h01});
		// Single-edge mode: pin 0 inverted input, pin 1 output
		wr(ADDR_GPIO_CTRL0 + 8'h01, 8'h00);
		wr(ADDR_DUAL_SEL, 8'h00);
		@(posedge CLK) gpio <= 6'h01;
		wr(ADDR_WAKE_STS2, 8'h3f);
		wr(ADDR_MISC_STS, 8'h3f);
		@(posedge CLK) gpio <= 6'h02;
		idle(3);
		rc(ADDR_WAKE_STS2, 8'h01);
		rc(ADDR_MISC_STS, 8'h03);
		summarize();
	end
endmodule : testbench
`default_nettype wire
